/* File: hdl/vpc_pkg.sv */
// constants, register map and reset values for the video preamp control bank
// Operation
// R1 - third DAC register holds eight bits, all driven as DAC3 level
// R2 - fourth DAC register holds eight bits, all driven as DAC4 level
// R3 - offset register bits 2-0 give shared video DC offset
// R4 - offset register bits 4-3 give overlay contrast code
// R5 - global bit 0 set blanks video, clear passes video
// R6 - global bit 1 set powers down analog circuits for sleep
// R7 - host writes zero to global bits 2 and 5
// R8 - global bit 3 halves range of DACs 1-3
// R9 - global bit 4 mixes half of DAC4 into DACs 1-3
// R10 - host writes zero to increment mode test bit
// R11 - clamp register bits 2-0 select bandwidth, default 100
// R12 - clamp register bit 3 selects clamp polarity, zero positive
// R13 - writing one to soft reset bit reloads all other defaults
// R14 - soft reset aborts operations but not serial transaction in flight
// R15 - soft reset bit clears itself when reset completes
// R16 - increment enable zero advances address after each data byte
// R17 - reserved bits ignore writes and read zero
package vpc_pkg;
  localparam logic [7:0] ADDR_DAC3 = 8'h06;
  localparam logic [7:0] ADDR_DAC4 = 8'h07;
  localparam logic [7:0] ADDR_OFS = 8'h08;
  localparam logic [7:0] ADDR_GLB = 8'h09;
  localparam logic [7:0] ADDR_INC = 8'h0a;
  localparam logic [7:0] ADDR_CLB = 8'h0b;
  localparam logic [7:0] ADDR_SOFT_RESET_TRIGGER = 8'h0f;
  localparam logic [7:0] DEF_DAC = 8'h80;
  localparam logic [7:0] DEF_OFS = 8'h15;
  localparam logic [7:0] DEF_GLB = 8'h00;
  localparam logic [7:0] DEF_INC = 8'h00;
  localparam logic [7:0] DEF_CLB = 8'h04;
  localparam logic [7:0] MASK_DAC = 8'hff;
  localparam logic [7:0] MASK_OFS = 8'h1f;
  localparam logic [7:0] MASK_GLB = 8'h3f;
  localparam logic [7:0] MASK_INC = 8'h03;
  localparam logic [7:0] MASK_CLB = 8'h0f;
  localparam logic [7:0] MASK_SOFT_RESET_TRIGGER = 8'h01;
  localparam int OFS_LSB = 0;
  localparam int OFS_MSB = 2;
  localparam int OSD_LSB = 3;
  localparam int OSD_MSB = 4;
  localparam int GLB_BLANK = 0;
  localparam int GLB_PWR = 1;
  localparam int GLB_HALF = 3;
  localparam int GLB_MIX = 4;
  localparam int INC_EN_BIT = 0;
  localparam int CLB_BW_MSB = 2;
  localparam int CLB_POL = 3;
  localparam int SOFT_RESET_TRIGGER_BIT = 0;
  localparam logic [7:0] ADDR_ONE = 8'h01;
  localparam logic [7:0] ADDR_DEF = 8'h00;
  localparam logic [7:0] RD_DEF = 8'h00;
  localparam int CLB_BW_LSB = 0;
endpackage : vpc_pkg

/* File: hdl/vpc_regs.sv */
// control register bank behind the serial byte interface
`timescale 1ns/1ps
module vpc_regs (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // byte interface from serial protocol engine
  input wire logic addr_load_in,
  input wire logic [7:0] addr_in,
  input wire logic wr_stb_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_stb_in,
  output logic [7:0] rd_data_out,
  output logic soft_reset_active_out,
  // analog control levels
  output logic [7:0] dac3_level_out,
  output logic [7:0] dac4_level_out,
  output logic [2:0] video_offset_code_out,
  output logic [1:0] overlay_contrast_code_out,
  output logic blank_video_out,
  output logic power_save_out,
  output logic dac123_half_range_out,
  output logic dac4_mix_enable_out,
  output logic [2:0] bandwidth_select_out,
  output logic clamp_polarity_out
);
  // pointer state
  logic [7:0] addr_reg;
  logic [7:0] addr_next;

  // level and control registers
  logic [7:0] dac3_reg;
  logic [7:0] dac3_next;
  logic [7:0] dac4_reg;
  logic [7:0] dac4_next;
  logic [7:0] ofs_reg;
  logic [7:0] ofs_next;
  logic [7:0] glb_reg;
  logic [7:0] glb_next;
  logic [7:0] inc_reg;
  logic [7:0] inc_next;
  logic [7:0] clb_reg;
  logic [7:0] clb_next;

  // self-clearing soft reset
  logic soft_reset_trigger_reg;
  logic soft_reset_trigger_next;

  // read capture
  logic [7:0] rd_reg;
  logic [7:0] rd_next;
  logic [7:0] rd_mux;

  // strobe decode
  logic load_sel;
  logic wr_sel;
  logic rd_sel;
  logic step_sel;

  // write address hits
  logic hit_dac3;
  logic hit_dac4;
  logic hit_ofs;
  logic hit_glb;
  logic hit_inc;
  logic hit_clb;
  logic hit_soft_reset_trigger;

  // masked write values
  logic [7:0] wr_dac_val;
  logic [7:0] wr_ofs_val;
  logic [7:0] wr_glb_val;
  logic [7:0] wr_inc_val;
  logic [7:0] wr_clb_val;

  // one strobe per edge: pointer load first, then write, then read
  always_comb begin
    load_sel = addr_load_in;
    wr_sel = !addr_load_in && wr_stb_in;
    rd_sel = !addr_load_in && !wr_stb_in && rd_stb_in;
    step_sel = (wr_sel || rd_sel) && !inc_reg[vpc_pkg::INC_EN_BIT]; // see R16
  end

  // a write lands only on the register the pointer names
  always_comb begin
    hit_dac3 = wr_sel && (addr_reg == vpc_pkg::ADDR_DAC3);
    hit_dac4 = wr_sel && (addr_reg == vpc_pkg::ADDR_DAC4);
    hit_ofs = wr_sel && (addr_reg == vpc_pkg::ADDR_OFS);
    hit_glb = wr_sel && (addr_reg == vpc_pkg::ADDR_GLB);
    hit_inc = wr_sel && (addr_reg == vpc_pkg::ADDR_INC);
    hit_clb = wr_sel && (addr_reg == vpc_pkg::ADDR_CLB);
    hit_soft_reset_trigger = wr_sel && (addr_reg == vpc_pkg::ADDR_SOFT_RESET_TRIGGER);
  end

  // reserved bits are dropped before they are stored
  always_comb begin
    wr_dac_val = wr_data_in & vpc_pkg::MASK_DAC;
    wr_ofs_val = wr_data_in & vpc_pkg::MASK_OFS; // see R17
    wr_glb_val = wr_data_in & vpc_pkg::MASK_GLB;
    wr_inc_val = wr_data_in & vpc_pkg::MASK_INC;
    wr_clb_val = wr_data_in & vpc_pkg::MASK_CLB;
  end

  // register at the current pointer, reserved bits masked to zero
  always_comb begin
    case (addr_reg)
      vpc_pkg::ADDR_DAC3: begin
        rd_mux = dac3_reg; // see R1
      end
      vpc_pkg::ADDR_DAC4: begin
        rd_mux = dac4_reg; // see R2
      end
      vpc_pkg::ADDR_OFS: begin
        rd_mux = ofs_reg & vpc_pkg::MASK_OFS; // see R17
      end
      vpc_pkg::ADDR_GLB: begin
        rd_mux = glb_reg & vpc_pkg::MASK_GLB;
      end
      vpc_pkg::ADDR_INC: begin
        rd_mux = inc_reg & vpc_pkg::MASK_INC;
      end
      vpc_pkg::ADDR_CLB: begin
        rd_mux = clb_reg & vpc_pkg::MASK_CLB;
      end
      vpc_pkg::ADDR_SOFT_RESET_TRIGGER: begin
        rd_mux = {7'h00, soft_reset_trigger_reg}; // see R15
      end
      default: begin
        rd_mux = vpc_pkg::RD_DEF;
      end
    endcase
  end

  // pointer wraps past the top; soft reset leaves it alone so the
  // serial transfer in flight keeps its place
  always_comb begin
    addr_next = addr_reg; // see R14
    if (load_sel) begin
      addr_next = addr_in;
    end else if (step_sel) begin
      addr_next = addr_reg + vpc_pkg::ADDR_ONE; // see R16
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_reg <= vpc_pkg::ADDR_DEF;
    end else begin
      addr_reg <= addr_next;
    end
  end

  // third dac level; all eight bits reach the dac
  // no reserved bits, so the write mask keeps every bit
  always_comb begin
    dac3_next = dac3_reg;

    if (soft_reset_trigger_reg) begin
      dac3_next = vpc_pkg::DEF_DAC; // see R13
    end

    // a write in the reload cycle wins over the default
    if (hit_dac3) begin
      dac3_next = wr_dac_val;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dac3_reg <= vpc_pkg::DEF_DAC;
    end else begin
      dac3_reg <= dac3_next;
    end
  end

  // fourth dac level, also the source of the optional mix
  // into the other three dacs
  always_comb begin
    dac4_next = dac4_reg;

    if (soft_reset_trigger_reg) begin
      dac4_next = vpc_pkg::DEF_DAC; // see R13
    end

    // a write in the reload cycle wins over the default
    if (hit_dac4) begin
      dac4_next = wr_dac_val;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dac4_reg <= vpc_pkg::DEF_DAC;
    end else begin
      dac4_reg <= dac4_next;
    end
  end

  // shared video offset and overlay contrast; the top three
  // bits are reserved and never stored
  always_comb begin
    ofs_next = ofs_reg;

    if (soft_reset_trigger_reg) begin
      ofs_next = vpc_pkg::DEF_OFS; // see R13
    end

    // a write in the reload cycle wins over the default
    if (hit_ofs) begin
      ofs_next = wr_ofs_val;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ofs_reg <= vpc_pkg::DEF_OFS;
    end else begin
      ofs_reg <= ofs_next;
    end
  end

  // global video controls; the two must-be-zero bits are kept as
  // written, the host is expected to leave them at zero
  always_comb begin
    glb_next = glb_reg;

    if (soft_reset_trigger_reg) begin
      glb_next = vpc_pkg::DEF_GLB; // see R13
    end

    // a write in the reload cycle wins over the default
    if (hit_glb) begin
      glb_next = wr_glb_val;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      glb_reg <= vpc_pkg::DEF_GLB;
    end else begin
      glb_reg <= glb_next;
    end
  end

  // address step control; the test bit is kept as written,
  // the host is expected to leave it at zero
  always_comb begin
    inc_next = inc_reg;

    if (soft_reset_trigger_reg) begin
      inc_next = vpc_pkg::DEF_INC; // see R13
    end

    // a write in the reload cycle wins over the default
    if (hit_inc) begin
      inc_next = wr_inc_val;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      inc_reg <= vpc_pkg::DEF_INC;
    end else begin
      inc_reg <= inc_next;
    end
  end

  // bandwidth code and clamp polarity; the power-on value gives
  // a middle bandwidth and a positive clamp
  always_comb begin
    clb_next = clb_reg;

    if (soft_reset_trigger_reg) begin
      clb_next = vpc_pkg::DEF_CLB; // see R13
    end

    // a write in the reload cycle wins over the default
    if (hit_clb) begin
      clb_next = wr_clb_val;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clb_reg <= vpc_pkg::DEF_CLB;
    end else begin
      clb_reg <= clb_next;
    end
  end

  // set by a write, held for one cycle while the defaults load;
  // a new write in that cycle wins over the self-clear
  always_comb begin
    soft_reset_trigger_next = 1'b0; // see R15

    if (hit_soft_reset_trigger) begin
      soft_reset_trigger_next = wr_data_in[vpc_pkg::SOFT_RESET_TRIGGER_BIT]; // see R13
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      soft_reset_trigger_reg <= 1'b0;
    end else begin
      soft_reset_trigger_reg <= soft_reset_trigger_next;
    end
  end

  // read byte holds until the next read strobe
  always_comb begin
    rd_next = rd_reg;
    if (rd_sel) begin
      rd_next = rd_mux;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_reg <= vpc_pkg::RD_DEF;
    end else begin
      rd_reg <= rd_next;
    end
  end

  // outputs straight from flip-flops
  // read side
  assign rd_data_out = rd_reg;
  assign soft_reset_active_out = soft_reset_trigger_reg;

  // dac levels
  assign dac3_level_out = dac3_reg; // see R1
  assign dac4_level_out = dac4_reg; // see R2

  // offset and overlay contrast
  assign video_offset_code_out =
    ofs_reg[vpc_pkg::OFS_MSB:vpc_pkg::OFS_LSB]; // see R3
  assign overlay_contrast_code_out =
    ofs_reg[vpc_pkg::OSD_MSB:vpc_pkg::OSD_LSB]; // see R4

  // global video controls
  assign blank_video_out = glb_reg[vpc_pkg::GLB_BLANK]; // see R5
  assign power_save_out = glb_reg[vpc_pkg::GLB_PWR]; // see R6
  assign dac123_half_range_out = glb_reg[vpc_pkg::GLB_HALF]; // see R8
  assign dac4_mix_enable_out = glb_reg[vpc_pkg::GLB_MIX]; // see R9

  // clamp and bandwidth
  assign bandwidth_select_out =
    clb_reg[vpc_pkg::CLB_BW_MSB:vpc_pkg::CLB_BW_LSB]; // see R11
  assign clamp_polarity_out = clb_reg[vpc_pkg::CLB_POL]; // see R12
endmodule : vpc_regs

/* File: verif/vpc_regs_props.sv */
// port assertions for the control register bank
`timescale 1ns/1ps
module vpc_props (
  input wire logic sys_clk_in, rst_b_in, wr_stb_in, rd_stb_in,
  input wire logic soft_reset_active_out, power_save_out,
  input wire logic [7:0] rd_data_out, dac3_level_out, dac4_level_out,
  input wire logic [2:0] video_offset_code_out, bandwidth_select_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic sr;
  // a write in the reload cycle wins, so it is left out
  assign sr = soft_reset_active_out & !wr_stb_in;
  chk_soft_reset_trigger_one: assert property (
    soft_reset_active_out |=> !soft_reset_active_out) else $error("soft_reset_trigger");
  chk_soft_reset_trigger_cause: assert property (
    $rose(soft_reset_active_out) |-> $past(wr_stb_in)) else $error("cause");
  chk_dac_def: assert property (sr |=>
    dac3_level_out == 8'h80 && dac4_level_out == 8'h80) else $error("dac");
  chk_ofs_def: assert property (sr |=>
    video_offset_code_out == 3'h5) else $error("offset");
  chk_bw_def: assert property (sr |=>
    bandwidth_select_out == 3'h4) else $error("bandwidth");
  chk_pwr_def: assert property (sr |=>
    !power_save_out) else $error("power save");
  chk_dac_hold: assert property (!wr_stb_in && !sr |=>
    $stable({dac3_level_out, dac4_level_out})) else $error("dac moved");
  chk_read_hold: assert property (!rd_stb_in |=>
    $stable(rd_data_out)) else $error("read moved");
  cover property (sr);
  cover property (rd_stb_in ##1 rd_data_out != 8'h00);
  cover property (wr_stb_in ##1 power_save_out);
endmodule : vpc_props
bind vpc_regs vpc_props chk (.*);

/* File: verif/vpc_host.sv */
// byte engine model: one strobe per call, launched just after an edge
`timescale 1ns/1ps
module vpc_host (
  input wire logic clk_in,
  output logic [2:0] s_out = 3'h0,
  output logic [7:0] a_out = 8'h00
);
  task automatic op(input logic [2:0] s, input logic [7:0] v);
    @(posedge clk_in) #1;
    s_out = s;
    a_out = v;
    @(posedge clk_in) #1;
    s_out = 3'h0;
    // released lines flip so a stale byte cannot pass as fresh
    a_out = ~v;
  endtask : op
endmodule : vpc_host

/* File: verif/vpc_regs_bench.sv */
// self-checking bench for the control register bank
`timescale 1ns/1ps
module vpc_regs_bench;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic sa, bv, ps, hr, mx, cp;
  logic [2:0] s, vo, bw;
  logic [7:0] a, q, d3, d4;
  logic [1:0] oc;
  int num_errors = 0;
  int n_compared = 0;
  int m[16];
  int k[16] = '{0, 0, 0, 0, 0, 0, 255, 255, 31, 63, 3, 15, 0, 0, 0, 0};
  int lf = 49;
  int v;
  always #50 sys_clk_in = ~sys_clk_in;
  vpc_host host (.clk_in(sys_clk_in), .s_out(s), .a_out(a));
  vpc_regs DUT (.sys_clk_in, .rst_b_in, .addr_load_in(s[2]), .addr_in(a),
    .wr_stb_in(s[1]), .wr_data_in(a), .rd_stb_in(s[0]), .rd_data_out(q),
    .soft_reset_active_out(sa), .dac3_level_out(d3), .dac4_level_out(d4),
    .video_offset_code_out(vo), .overlay_contrast_code_out(oc),
    .blank_video_out(bv), .power_save_out(ps), .dac123_half_range_out(hr),
    .dac4_mix_enable_out(mx), .bandwidth_select_out(bw),
    .clamp_polarity_out(cp));
  function automatic int nx(int x);
    return {x[6:0], ^(x[7:0] & 8'hb8)};
  endfunction : nx
  task automatic cmp(string n, logic [28:0] e, logic [28:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic outs();
    cmp("outputs", {m[6][7:0], m[7][7:0], m[8][4:0], m[9][4:3], m[9][1:0],
      m[11][3:0]}, {d3, d4, oc, vo, mx, hr, ps, bv, cp, bw});
  endtask : outs
  task automatic give_verdict();
    $display("mismatches %0d of %0d compared", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge sys_clk_in);
    #1 rst_b_in = 1'b1;
    m = '{6: 128, 7: 128, 8: 21, 11: 4, default: 0};
    outs();
    host.op(3'h4, 8'h00);
    for (int i = 0; i < 15; i++) begin
      lf = nx(lf);
      v = (i == 10) ? 0 : (i == 9) ? lf & 'hdb : lf;
      host.op(3'h2, v[7:0]);
      m[i] = v & k[i];
    end
    outs();
    host.op(3'h4, 8'h00);
    for (int i = 0; i < 16; i++) begin
      host.op(3'h1, 8'h00);
      cmp("read", m[i], q);
    end
    host.op(3'h4, 8'h0f);
    host.op(3'h2, 8'h01);
    cmp("reset pulse", 1, sa);
    m = '{6: 128, 7: 128, 8: 21, 11: 4, default: 0};
    host.op(3'h4, 8'h0f);
    outs();
    cmp("reset low", 0, sa);
    host.op(3'h1, 8'h00);
    cmp("reset bit", 0, q);
    host.op(3'h4, 8'h0a);
    host.op(3'h2, 8'h01);
    host.op(3'h4, 8'h07);
    host.op(3'h2, 8'h3c);
    host.op(3'h2, 8'h5a);
    m[7] = 'h5a;
    outs();
    give_verdict();
  end
endmodule : vpc_regs_bench
